// ===== design/cida_core.v
// index/data access unit for five configuration registers
`timescale 1ns/100ps
`include "cida_consts.vh"
// Function
// R1: five configuration registers held here
// R2: reset loads strap defaults into first three
// R3: control and printer registers load by software
// R4: host selects register by index 00h to 04h
// R5: first index read returns identification byte once
// R6: second index read after reset returns 00h
// R7: later index reads return last written index
// R8: index bits 3 to 6 read zero
// R9: data commits on second consecutive data write
// R10: host writes value twice, interrupts off
// R11: host read-modify-write then double write
// R12: data read returns selected register
// R13: single reads have no configuration side effect
// R14: pin mux bit clear: zero-wait open drain
// R15: pin mux bit set: power-down or chip select
// R16: any other access breaks write pairing
// R17: index above 04h reads zero, writes ignored
module cida_core (
   input  wire       I_SYS_CLK,
   input  wire       I_RST,
   input  wire       i_cs_idx,
   input  wire       i_cs_data,
   input  wire       i_rd_n,
   input  wire       i_wr_n,
   input  wire [7:0] i_data,
   input  wire [4:0] i_strap,
   input  wire       i_strap_ide_sec,
   input  wire       i_strap_pdn_clk,
   input  wire       i_epp_short_wr,
   input  wire       i_alt_pin_in,
   input  wire       i_chip_select_out,
   output reg  [7:0] O_DATA,
   output reg        O_DATA_OE,
   output reg  [7:0] O_FUNCTION_ENABLE_REG,
   output reg  [7:0] O_FUNCTION_ADDRESS_REG,
   output reg  [7:0] O_POWER_TEST_REG,
   output reg  [7:0] O_FUNCTION_CONTROL_REG,
   output reg  [7:0] O_PRINTER_CONTROL_REG,
   output reg        O_ZERO_WAIT_OUT,
   output reg        O_ZERO_WAIT_OE,
   output reg        O_POWER_DOWN_IN
);
   // id sequence states
   localparam [2:0] ST_ID   = 3'b001;
   localparam [2:0] ST_ZERO = 3'b010;
   localparam [2:0] ST_IDX  = 3'b100;

   // pin-side inputs pass two flops before use
   reg  [4:0] s1_q;
   reg  [4:0] s2_q;
   reg  [1:0] p1_q;
   reg  [1:0] p2_q;
   reg        rd_prev_q;
   reg        wr_prev_q;
   reg  [2:0] st_q;
   reg  [2:0] st_d;
   reg  [7:0] idx_q;
   reg        pair_q;
   reg        strap_load_q;
   reg  [7:0] rd_val;
   reg  [6:0] st1_q;
   reg  [4:0] strap_s_q;
   reg        strap_ide_q;
   reg        strap_pdn_q;
   reg  [7:0] d1_q;
   reg  [7:0] i_data_q;
   reg  [7:0] fer_d;
   reg  [7:0] far_d;
   reg  [7:0] ptr_d;
   reg  [7:0] fcr_d;
   reg  [7:0] pcr_d;
   wire [7:0] def_fer;
   wire [7:0] def_far;
   wire [7:0] def_ptr;
   wire       rd_n_s;
   wire       wr_n_s;
   wire       cs_idx_s;
   wire       cs_data_s;
   wire       rd_strobe;
   wire       wr_strobe;
   wire       idx_ok;
   wire [4:0] sel;
   wire       commit;

   // index within the implemented range
   function in_range;
      input [7:0] idx;
      begin
         in_range = (idx <= `CIDA_IDX_LAST);
      end
   endfunction

   // one-hot select of the implemented registers, all zero above the last index
   function [4:0] reg_sel;
      input [7:0] idx;
      begin
         reg_sel = 5'h00;
         if (idx == {5'h00, `CIDA_IDX_FER}) begin
            reg_sel = 5'h01;
         end else if (idx == {5'h00, `CIDA_IDX_FAR}) begin
            reg_sel = 5'h02;
         end else if (idx == {5'h00, `CIDA_IDX_PTR}) begin
            reg_sel = 5'h04;
         end else if (idx == {5'h00, `CIDA_IDX_FCR}) begin
            reg_sel = 5'h08;
         end else if (idx == {5'h00, `CIDA_IDX_PCR}) begin
            reg_sel = 5'h10;
         end
      end
   endfunction

   always @(posedge I_SYS_CLK) begin
      s1_q <= {i_cs_idx, i_cs_data, i_rd_n, i_wr_n, i_epp_short_wr};
      s2_q <= s1_q;
      p1_q <= {i_alt_pin_in, i_chip_select_out};
      p2_q <= p1_q;
   end

   assign cs_idx_s  = s2_q[4];
   assign cs_data_s = s2_q[3];
   assign rd_n_s    = s2_q[2];
   assign wr_n_s    = s2_q[1];
   // one pulse per falling strobe, so a held strobe counts as one access
   assign rd_strobe = ~rd_n_s & rd_prev_q;
   assign wr_strobe = ~wr_n_s & wr_prev_q;
   assign idx_ok    = in_range(idx_q);
   assign sel       = reg_sel(idx_q);
   // an index write in the same strobe takes priority over the data port
   assign commit    = wr_strobe & cs_data_s & ~cs_idx_s & pair_q;

   cida_strap_rom u_rom (
      .i_strap   (strap_s_q),
      .i_ide_sec (strap_ide_q),
      .i_pdn_clk (strap_pdn_q),
      .o_fer     (def_fer),
      .o_far     (def_far),
      .o_ptr     (def_ptr)
   );

   // straps are slow levels sampled through their own pair of flops
   always @(posedge I_SYS_CLK) begin
      st1_q       <= {i_strap, i_strap_ide_sec, i_strap_pdn_clk};
      strap_s_q   <= st1_q[6:2];
      strap_ide_q <= st1_q[1];
      strap_pdn_q <= st1_q[0];
   end

   // read mux: id byte, then zero, then the stored index
   always @* begin
      rd_val = 8'h00;
      if (cs_idx_s) begin
         if (st_q == ST_ID) begin
            rd_val = `CIDA_ID_BYTE; // [R5]
         end else if (st_q == ST_ZERO) begin
            rd_val = 8'h00; // [R6]
         end else begin
            rd_val = idx_q & `CIDA_IDX_RSVD_MASK; // [R7] [R8]
         end
      end else if (cs_data_s && idx_ok) begin
         if (sel[0]) begin
            rd_val = O_FUNCTION_ENABLE_REG; // [R12]
         end else if (sel[1]) begin
            rd_val = O_FUNCTION_ADDRESS_REG;
         end else if (sel[2]) begin
            rd_val = O_POWER_TEST_REG;
         end else if (sel[3]) begin
            rd_val = O_FUNCTION_CONTROL_REG;
         end else begin
            rd_val = O_PRINTER_CONTROL_REG;
         end
      end
   end

   // strap load wins over a host commit in the same clock
   // a host cannot reach the bus that early, so nothing is lost
   always @* begin
      fer_d = O_FUNCTION_ENABLE_REG;
      far_d = O_FUNCTION_ADDRESS_REG;
      ptr_d = O_POWER_TEST_REG;
      fcr_d = O_FUNCTION_CONTROL_REG;
      pcr_d = O_PRINTER_CONTROL_REG;
      if (strap_load_q) begin
         fer_d = def_fer; // [R2]
         far_d = def_far; // [R2]
         ptr_d = def_ptr; // [R2]
      end else if (commit) begin
         // the second write carries the committed value
         if (sel[0]) begin
            fer_d = i_data_q; // [R1] [R9]
         end
         if (sel[1]) begin
            far_d = i_data_q; // [R9]
         end
         if (sel[2]) begin
            ptr_d = i_data_q; // [R9]
         end
         if (sel[3]) begin
            fcr_d = i_data_q; // [R3] [R9]
         end
         if (sel[4]) begin
            pcr_d = i_data_q; // [R3] [R9] [R17]
         end
      end
   end

   // id sequence; an index write ends it early
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_ID: begin
            if (wr_strobe && cs_idx_s) begin
               st_d = ST_IDX;
            end else if (rd_strobe && cs_idx_s) begin
               st_d = ST_ZERO; // [R5]
            end
         end
         ST_ZERO: begin
            if ((rd_strobe || wr_strobe) && cs_idx_s) begin
               st_d = ST_IDX; // [R6]
            end
         end
         default: st_d = ST_IDX;
      endcase
   end

   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rd_prev_q    <= 1'b1;
         wr_prev_q    <= 1'b1;
         st_q         <= ST_ID;
         idx_q        <= 8'h00;
         pair_q       <= 1'b0;
         strap_load_q <= 1'b1;
         O_DATA       <= 8'h00;
         O_DATA_OE    <= 1'b0;
         O_FUNCTION_ENABLE_REG  <= 8'h00;
         O_FUNCTION_ADDRESS_REG <= 8'h00;
         O_POWER_TEST_REG       <= 8'h00;
         O_FUNCTION_CONTROL_REG <= `CIDA_FCR_RST; // [R3]
         O_PRINTER_CONTROL_REG  <= `CIDA_PCR_RST; // [R3]
      end else begin
         rd_prev_q <= rd_n_s;
         wr_prev_q <= wr_n_s;
         st_q      <= st_d;
         // straps caught on the first clock after release, never under reset
         strap_load_q <= 1'b0;
         O_FUNCTION_ENABLE_REG  <= fer_d;
         O_FUNCTION_ADDRESS_REG <= far_d;
         O_POWER_TEST_REG       <= ptr_d;
         O_FUNCTION_CONTROL_REG <= fcr_d;
         O_PRINTER_CONTROL_REG  <= pcr_d;
         O_DATA_OE <= ~rd_n_s & (cs_idx_s | cs_data_s);
         if (rd_strobe) begin
            O_DATA <= rd_val; // [R13]
         end
         if (wr_strobe && cs_idx_s) begin
            idx_q  <= i_data_q; // [R4]
            pair_q <= 1'b0; // [R16]
         end else if (wr_strobe && cs_data_s) begin
            // only the second value is kept; the first is not compared
            pair_q <= ~pair_q; // [R9]
         end else if (rd_strobe) begin
            pair_q <= 1'b0; // [R16]
         end
      end
   end

   // data bus sampled alongside the strobes
   always @(posedge I_SYS_CLK) begin
      d1_q     <= i_data;
      i_data_q <= d1_q;
   end

   // zero-wait pin mux; the shared pin is open drain in either role
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_ZERO_WAIT_OUT <= 1'b0;
         O_ZERO_WAIT_OE  <= 1'b0;
         O_POWER_DOWN_IN <= 1'b0;
      end else if (!O_FUNCTION_CONTROL_REG[`CIDA_FCR_PINMUX_BIT]) begin
         O_ZERO_WAIT_OUT <= 1'b0;
         O_ZERO_WAIT_OE  <= s2_q[0]; // [R14]
         O_POWER_DOWN_IN <= 1'b0;
      end else if (O_POWER_TEST_REG[0]) begin
         // pin used as active-low power-down input
         O_ZERO_WAIT_OUT <= 1'b0;
         O_ZERO_WAIT_OE  <= 1'b0;
         O_POWER_DOWN_IN <= ~p2_q[1]; // [R15]
      end else begin
         O_ZERO_WAIT_OUT <= 1'b0;
         O_ZERO_WAIT_OE  <= ~p2_q[0]; // [R15]
         O_POWER_DOWN_IN <= 1'b0;
      end
   end
endmodule

// ===== design/cida_consts.vh
// constants for the configuration index/data access block
`ifndef CIDA_CONSTS_VH
`define CIDA_CONSTS_VH
`define CIDA_IDX_FER        3'h0
`define CIDA_IDX_FAR        3'h1
`define CIDA_IDX_PTR        3'h2
`define CIDA_IDX_FCR        3'h3
`define CIDA_IDX_PCR        3'h4
`define CIDA_IDX_LAST       8'h04
`define CIDA_IDX_RSVD_MASK  8'h87
`define CIDA_ID_BYTE        8'h5A
`define CIDA_FCR_RST        8'h00
`define CIDA_PCR_RST        8'h00
`define CIDA_FCR_PINMUX_BIT 6
`define CIDA_ZWS_FER_RST    8'h00
`endif

// ===== design/cida_strap_rom.v
// strap-selected default values for the first three configuration registers
`timescale 1ns/100ps
module cida_strap_rom (
   input  wire [4:0] i_strap,
   input  wire       i_ide_sec,
   input  wire       i_pdn_clk,
   output reg  [7:0] o_fer,
   output reg  [7:0] o_far,
   output reg  [7:0] o_ptr
);
   // the bit 7 option of the enable and power values is a further strap
   always @* begin
      o_ptr = {i_pdn_clk, 7'h00};
      o_far = 8'h10;
      case (i_strap)
         5'h00: begin o_fer = 8'h4F; o_far = 8'h10; end
         5'h01: begin o_fer = 8'h4F; o_far = 8'h11; end
         5'h02: begin o_fer = 8'h4F; o_far = 8'h11; end
         5'h03: begin o_fer = 8'h4F; o_far = 8'h39; end
         5'h04: begin o_fer = 8'h4F; o_far = 8'h24; end
         5'h05: begin o_fer = 8'h4F; o_far = 8'h38; end
         5'h06: begin o_fer = 8'h4B; o_far = 8'h00; end
         5'h07: begin o_fer = 8'h4B; o_far = 8'h01; end
         5'h08: begin o_fer = 8'h4B; o_far = 8'h01; end
         5'h09: begin o_fer = 8'h4B; o_far = 8'h09; end
         5'h0A: begin o_fer = 8'h4B; o_far = 8'h08; end
         5'h0B: begin o_fer = 8'h4B; o_far = 8'h08; end
         5'h0C: begin o_fer = 8'h0F; o_far = 8'h10; end
         5'h0D: begin o_fer = 8'h0F; o_far = 8'h11; end
         5'h0E: begin o_fer = 8'h0F; o_far = 8'h39; end
         5'h0F: begin o_fer = 8'h0F; o_far = 8'h24; end
         5'h10: begin o_fer = 8'h49; o_far = 8'h00; end
         5'h11: begin o_fer = 8'h49; o_far = 8'h01; end
         5'h12: begin o_fer = 8'h49; o_far = 8'h01; end
         5'h13: begin o_fer = 8'h49; o_far = 8'h00; end
         5'h14: begin o_fer = 8'h07; o_far = 8'h10; end
         5'h15: begin o_fer = 8'h07; o_far = 8'h11; end
         5'h16: begin o_fer = 8'h07; o_far = 8'h39; end
         5'h17: begin o_fer = 8'h07; o_far = 8'h24; end
         5'h18: begin o_fer = 8'h47; o_far = 8'h10; end
         5'h19: begin o_fer = 8'h47; o_far = 8'h11; end
         5'h1A: begin o_fer = 8'h47; o_far = 8'h11; end
         5'h1B: begin o_fer = 8'h47; o_far = 8'h39; end
         5'h1C: begin o_fer = 8'h47; o_far = 8'h24; end
         5'h1D: begin o_fer = 8'h47; o_far = 8'h38; end
         5'h1E: begin o_fer = 8'h08; o_far = 8'h10; end
         default: begin
            o_fer = 8'h00;
            o_far = 8'h10;
            o_ptr = {i_pdn_clk, 7'h02};
         end
      endcase
      // secondary ide choice sets bit 7 only where ide is enabled
      if (o_fer[6] && i_ide_sec) begin
         o_fer = o_fer | 8'h80;
      end
   end
endmodule

// ===== test/cida_core_props.sv
// port assertions for the configuration index/data access unit
`timescale 1ns/100ps
module cida_core_props (
   input logic       I_SYS_CLK,
   input logic       I_RST,
   input logic       i_cs_idx,
   input logic       i_cs_data,
   input logic       i_rd_n,
   input logic       i_wr_n,
   input logic       i_epp_short_wr,
   input logic       i_alt_pin_in,
   input logic [7:0] O_DATA,
   input logic       O_DATA_OE,
   input logic [7:0] O_FUNCTION_ENABLE_REG,
   input logic [7:0] O_FUNCTION_ADDRESS_REG,
   input logic [7:0] O_POWER_TEST_REG,
   input logic [7:0] O_FUNCTION_CONTROL_REG,
   input logic [7:0] O_PRINTER_CONTROL_REG,
   input logic       O_ZERO_WAIT_OUT,
   input logic       O_ZERO_WAIT_OE,
   input logic       O_POWER_DOWN_IN
);
   logic seen_q;
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);
   // first index read carries the id byte, so it is left out of the zero-bit check
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         seen_q <= 1'b0;
      end else if ($fell(i_rd_n) && i_cs_idx) begin
         seen_q <= 1'b1;
      end
   end
   sequence idx_read_start;
      $fell(i_rd_n) && i_cs_idx;
   endsequence
   sequence quiet_bus;
      (i_wr_n && !$past(I_RST) && !$past(I_RST, 2)) [*6];
   endsequence
   oe_on_read_a: assert property (
      $fell(i_rd_n) && (i_cs_idx || i_cs_data) |-> ##[2:4] O_DATA_OE)
      else $error("read enable missing");
   oe_idle_a: assert property (i_rd_n [*5] |-> !O_DATA_OE)
      else $error("read enable without read");
   cfg_quiet_a: assert property (quiet_bus |-> $stable({O_FUNCTION_ENABLE_REG,
      O_FUNCTION_ADDRESS_REG, O_POWER_TEST_REG, O_FUNCTION_CONTROL_REG, O_PRINTER_CONTROL_REG}))
      else $error("register changed without write");
   idx_rsvd_a: assert property (
      idx_read_start and seen_q |-> ##5 (O_DATA[6:3] == 4'h0))
      else $error("reserved index bits set");
   zws_mux_a: assert property ((!O_FUNCTION_CONTROL_REG[6] && !$past(I_RST)
      && $stable(i_epp_short_wr)) [*4] |-> (O_ZERO_WAIT_OE == i_epp_short_wr))
      else $error("zero wait pull wrong");
   zws_low_a: assert property (O_ZERO_WAIT_OE |-> !O_ZERO_WAIT_OUT)
      else $error("zero wait driven high");
   power_down_in_role_a: assert property ((O_FUNCTION_CONTROL_REG[6] && O_POWER_TEST_REG[0]
      && !$past(I_RST) && $stable(i_alt_pin_in)) [*4]
      |-> (O_POWER_DOWN_IN == !i_alt_pin_in) && !O_ZERO_WAIT_OE)
      else $error("power down role wrong");
   ctl_reset_a: assert property ($fell(I_RST) |-> ##1
      (O_FUNCTION_CONTROL_REG == 8'h00 && O_PRINTER_CONTROL_REG == 8'h00))
      else $error("control registers not cleared");
endmodule

// ===== test/cida_host_model.sv
// host processor model driving the index/data port strobes
`timescale 1ns/100ps
module cida_host_model (
   input  logic       clk,
   input  logic [7:0] rdata,
   output logic       cs_idx,
   output logic       cs_data,
   output logic       rd_n,
   output logic       wr_n,
   output logic [7:0] wdata
);
   initial begin
      cs_idx = 1'b0;
      cs_data = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      wdata = 8'hA5;
   end
   // strobes stay 6 clocks low and high, twice the synchroniser minimum
   task acc(input logic i, input logic w, input logic [7:0] d, output logic [7:0] q);
      begin
         @(posedge clk);
         #1;
         cs_idx = i;
         cs_data = !i;
         wdata = d;
         rd_n = w;
         wr_n = !w;
         repeat (6) @(posedge clk);
         q = rdata;
         #1;
         cs_idx = 1'b0;
         cs_data = 1'b0;
         rd_n = 1'b1;
         wr_n = 1'b1;
         // a released bus must not keep its last value
         wdata = ~d;
         repeat (5) @(posedge clk);
      end
   endtask
endmodule

// ===== test/cida_core_tb_top.sv
// self-checking bench for the configuration index/data access unit
`timescale 1ns/100ps
module cida_core_tb_top;
   reg         clk;
   reg         rst;
   reg         epp;
   reg         alt;
   reg         cso;
   wire        cs_i;
   wire        cs_d;
   wire        rd_n;
   wire        wr_n;
   wire [7:0]  wd;
   wire [7:0]  rdat;
   wire [7:0]  r_en;
   wire [7:0]  r_addr;
   wire [7:0]  r_pwr;
   wire [7:0]  r_ctl;
   wire [7:0]  r_prn;
   wire        zw_oe;
   wire        pdn;
   integer     bad_count;
   integer     checks;
   integer     cyc;
   cida_host_model host (.clk(clk), .rdata(rdat), .cs_idx(cs_i), .cs_data(cs_d),
      .rd_n(rd_n), .wr_n(wr_n), .wdata(wd));
   // all-zero strap set: defaults known, strap decode beyond that is not reached
   cida_core dut (.I_SYS_CLK(clk), .I_RST(rst), .i_cs_idx(cs_i), .i_cs_data(cs_d),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wd), .i_strap(5'h00), .i_strap_ide_sec(1'b0),
      .i_strap_pdn_clk(1'b0), .i_epp_short_wr(epp), .i_alt_pin_in(alt),
      .i_chip_select_out(cso), .O_DATA(rdat), .O_DATA_OE(), .O_FUNCTION_ENABLE_REG(r_en),
      .O_FUNCTION_ADDRESS_REG(r_addr), .O_POWER_TEST_REG(r_pwr),
      .O_FUNCTION_CONTROL_REG(r_ctl), .O_PRINTER_CONTROL_REG(r_prn),
      .O_ZERO_WAIT_OUT(), .O_ZERO_WAIT_OE(zw_oe), .O_POWER_DOWN_IN(pdn));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end
   task chk(input [39:0] got, input [39:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input i, input [7:0] d);
      reg [7:0] q;
      begin
         host.acc(i, 1'b1, d, q);
      end
   endtask
   task rd(input i, input [7:0] exp);
      reg [7:0] q;
      begin
         host.acc(i, 1'b0, 8'h00, q);
         chk({32'h0, q}, {32'h0, exp});
      end
   endtask
   task set(input [7:0] i, input [7:0] d);
      begin
         wr(1'b1, i);
         wr(1'b0, d);
         wr(1'b0, d);
      end
   endtask
   task cfg(input [39:0] exp);
      begin
         chk({r_en, r_addr, r_pwr, r_ctl, r_prn}, exp);
      end
   endtask
   task pin(input e, input a, input [1:0] exp);
      begin
         @(posedge clk);
         #1;
         epp = e;
         alt = a;
         repeat (5) @(posedge clk);
         chk({38'h0, zw_oe, pdn}, {38'h0, exp});
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      epp = 1'b0;
      alt = 1'b1;
      cso = 1'b1;
      bad_count = 0;
      checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1 cfg(40'h4F10000000);
      rd(1'b1, 8'h5A);
      rd(1'b1, 8'h00);
      cfg(40'h4F10000000);
      $display("id test done");
      wr(1'b1, 8'h03);
      wr(1'b0, 8'h40);
      cfg(40'h4F10000000);
      wr(1'b0, 8'h40);
      cfg(40'h4F10004000);
      rd(1'b0, 8'h40);
      rd(1'b1, 8'h03);
      wr(1'b1, 8'h04);
      wr(1'b0, 8'h21);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h21);
      cfg(40'h4F10004000);
      wr(1'b0, 8'h21);
      cfg(40'h4F10004021);
      $display("pairing test done");
      wr(1'b1, 8'hFB);
      rd(1'b1, 8'h83);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'hFF);
      wr(1'b0, 8'hFF);
      cfg(40'h4F10004021);
      $display("range test done");
      set(8'h02, 8'h01);
      pin(1'b1, 1'b0, 2'b01);
      pin(1'b1, 1'b1, 2'b00);
      set(8'h02, 8'h00);
      #1 cso = 1'b0;
      pin(1'b0, 1'b1, 2'b10);
      #1 cso = 1'b1;
      pin(1'b0, 1'b1, 2'b00);
      set(8'h03, 8'h00);
      pin(1'b1, 1'b1, 2'b10);
      pin(1'b0, 1'b1, 2'b00);
      $display("pin test done");
      complete_run;
   end
endmodule
bind cida_core cida_core_props u_props (.I_SYS_CLK, .I_RST, .i_cs_idx, .i_cs_data, .i_rd_n,
   .i_wr_n, .i_epp_short_wr, .i_alt_pin_in, .O_DATA, .O_DATA_OE, .O_FUNCTION_ENABLE_REG,
   .O_FUNCTION_ADDRESS_REG, .O_POWER_TEST_REG, .O_FUNCTION_CONTROL_REG,
   .O_PRINTER_CONTROL_REG, .O_ZERO_WAIT_OUT, .O_ZERO_WAIT_OE, .O_POWER_DOWN_IN);
